// ==== rtl/t8cf_pkg.sv ====
// Package with register map, field layout and mode codes of the timer flags.
package t8cf_pkg;
    // Data-space offsets of the registers this block decodes.
    localparam logic [15:0] T8CF_OFF_FLAGS   = 16'h0035;
    localparam logic [15:0] T8CF_OFF_COUNT   = 16'h0046;
    localparam logic [15:0] T8CF_OFF_CMP_A   = 16'h0047;
    localparam logic [15:0] T8CF_OFF_CMP_B   = 16'h0048;
    localparam logic [15:0] T8CF_OFF_MASK    = 16'h006E;
    // The short I/O window sits this far below the data-space offset.
    localparam logic [15:0] T8CF_IO_SHIFT    = 16'h0020;
    localparam logic [15:0] T8CF_IO_LIMIT    = 16'h003F;
    // From here upward only data-space access reaches a register.
    localparam logic [15:0] T8CF_EXT_BASE    = 16'h0060;
    // Flag and enable bit positions, shared by both registers.
    localparam int          T8CF_BIT_OVF     = 0;
    localparam int          T8CF_BIT_CMP_A   = 1;
    localparam int          T8CF_BIT_CMP_B   = 2;
    localparam int          T8CF_NFLAGS      = 3;
    // Reset values.
    localparam logic [7:0]  T8CF_RST_BYTE    = 8'h00;
    localparam logic [2:0]  T8CF_RST_FLAGS   = 3'h0;
    // Counter end points.
    localparam logic [7:0]  T8CF_COUNT_FLOOR = 8'h00;
    localparam logic [7:0]  T8CF_COUNT_MAX   = 8'hFF;
    // Waveform generation modes as seen on the mode bits.
    typedef enum logic [2:0] {
        T8CF_MODE_NORMAL   = 3'b000,
        T8CF_MODE_PC_MAX   = 3'b001,
        T8CF_MODE_CTC      = 3'b010,
        T8CF_MODE_FAST_MAX = 3'b011,
        T8CF_MODE_RSV4     = 3'b100,
        T8CF_MODE_PC_TOP   = 3'b101,
        T8CF_MODE_RSV6     = 3'b110,
        T8CF_MODE_FAST_TOP = 3'b111
    } t8cf_mode_t;
endpackage

// ==== rtl/t8cf_match.sv ====
// One compare channel: equality check against the counter on each tick.
`timescale 1ns/1ps
module t8cf_match (
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_tick,
    input  wire logic [7:0] i_count,
    input  wire logic [7:0] i_compare,
    input  wire logic       i_block,
    input  wire logic       i_force,
    output logic            o_match,
    output logic            o_wave
);
    logic match_reg;
    logic match_next;
    logic wave_reg;
    logic wave_next;

    // Equality is checked every tick; a blocked tick yields nothing.
    always_comb begin
        match_next = i_tick && (i_count == i_compare) && !i_block;
        // Forcing drives the waveform only, never the flag path.
        wave_next  = match_next || i_force;
    end

    // Registered strobes keep the outputs free of compare glitches.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            match_reg <= 1'b0;
            wave_reg  <= 1'b0;
        end else begin
            match_reg <= match_next;
            wave_reg  <= wave_next;
        end
    end

    assign o_match = match_reg;
    assign o_wave  = wave_reg;

    property p_force_no_match;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_force && !i_tick) |=> !o_match;
    endproperty
    a_force_no_match: assert property (p_force_no_match)
        else $error("Forced compare produced a match strobe.");
endmodule // t8cf_match

// ==== rtl/t8cf_top.sv ====
// Compare registers, interrupt flags and interrupt gating of an 8-bit timer.
`timescale 1ns/1ps
module t8cf_top
    import t8cf_pkg::*;
(
    input  wire logic               i_clk,
    input  wire logic               i_sys_rst,
    input  wire logic [5:0]         i_io_addr,
    input  wire logic               i_io_wr,
    input  wire logic               i_io_rd,
    input  wire logic [15:0]        i_ds_addr,
    input  wire logic               i_ds_wr,
    input  wire logic               i_ds_rd,
    input  wire logic [7:0]         i_wdata,
    output logic [7:0]              o_rdata,
    output logic                    o_rd_ack,
    input  wire logic               i_timer_tick,
    input  wire logic [7:0]         i_timer8_count_value,
    input  t8cf_pkg::t8cf_mode_t    i_waveform_mode_bits,
    input  wire logic               i_force_compare_a_strobe,
    input  wire logic               i_force_compare_b_strobe,
    input  wire logic               i_global_irq_enable,
    input  wire logic               i_vector_ack_overflow,
    input  wire logic               i_vector_ack_compare_a,
    input  wire logic               i_vector_ack_compare_b,
    output logic                    o_count_load,
    output logic [7:0]              o_count_load_data,
    output logic                    o_waveform_out_a,
    output logic                    o_waveform_out_b,
    output logic                    o_clear_on_match_a,
    output logic                    o_clear_on_match_b,
    output logic                    o_irq_overflow,
    output logic                    o_irq_compare_a,
    output logic                    o_irq_compare_b
);
    import t8cf_pkg::*;

    // Register state and next values.
    logic [7:0]             compare_a_value_reg;
    logic [7:0]             compare_a_value_next;
    logic [7:0]             compare_b_value_reg;
    logic [7:0]             compare_b_value_next;
    logic [T8CF_NFLAGS-1:0] timer8_flag_register_reg;
    logic [T8CF_NFLAGS-1:0] timer8_flag_register_next;
    logic [T8CF_NFLAGS-1:0] irq_enable_reg;
    logic [T8CF_NFLAGS-1:0] irq_enable_next;
    logic                   block_reg;
    logic                   block_next;
    logic [7:0]             rdata_reg;
    logic [7:0]             rdata_next;
    logic                   rd_ack_reg;
    logic                   rd_ack_next;
    logic                   load_reg;
    logic                   load_next;
    logic [7:0]             load_data_reg;
    logic [7:0]             load_data_next;

    // Decoded strobes and event vectors.
    logic                   wr_flags;
    logic                   wr_count;
    logic                   wr_cmp_a;
    logic                   wr_cmp_b;
    logic                   wr_mask;
    logic                   rd_any;
    logic [T8CF_NFLAGS-1:0] flag_set;
    logic [T8CF_NFLAGS-1:0] flag_clr;
    logic [T8CF_NFLAGS-1:0] vector_ack;
    logic [1:0]             chan_match;
    logic [1:0]             chan_wave;
    logic [7:0]             chan_compare [2];
    logic [1:0]             chan_force;
    logic                   ovf_hit;

    // A register is selected over data space by its offset, or over the
    // short I/O window by offset minus the shift, but only below the
    // extended base, which the short opcodes cannot reach at all.
    function automatic logic reg_sel(
        input logic        ds_en,
        input logic [15:0] ds_addr,
        input logic        io_en,
        input logic [5:0]  io_addr,
        input logic [15:0] off
    );
        logic        ds_hit;
        logic        io_hit;
        logic [15:0] io_full;
        ds_hit  = ds_en && (ds_addr == off);
        io_full = {10'h000, io_addr} + T8CF_IO_SHIFT;
        io_hit  = io_en && (off < T8CF_EXT_BASE) &&
                  ((off - T8CF_IO_SHIFT) <= T8CF_IO_LIMIT) &&
                  (io_full == off);
        return ds_hit || io_hit;
    endfunction

    // Overflow point per mode: dual-slope modes flag at the floor,
    // fast mode with a compare top flags at compare A, others at max.
    function automatic logic ovf_point(
        input t8cf_mode_t mode,
        input logic [7:0] count,
        input logic [7:0] top_a
    );
        logic hit;
        hit = 1'b0;
        case (mode)
            T8CF_MODE_PC_MAX:   hit = (count == T8CF_COUNT_FLOOR);
            T8CF_MODE_PC_TOP:   hit = (count == T8CF_COUNT_FLOOR);
            T8CF_MODE_FAST_TOP: hit = (count == top_a);
            T8CF_MODE_NORMAL:   hit = (count == T8CF_COUNT_MAX);
            T8CF_MODE_CTC:      hit = (count == T8CF_COUNT_MAX);
            T8CF_MODE_FAST_MAX: hit = (count == T8CF_COUNT_MAX);
            default:            hit = (count == T8CF_COUNT_MAX);
        endcase
        return hit;
    endfunction

    // Address decode for both access paths.
    always_comb begin
        wr_flags = reg_sel(i_ds_wr, i_ds_addr, i_io_wr, i_io_addr,
                           T8CF_OFF_FLAGS);
        wr_count = reg_sel(i_ds_wr, i_ds_addr, i_io_wr, i_io_addr,
                           T8CF_OFF_COUNT);
        wr_cmp_a = reg_sel(i_ds_wr, i_ds_addr, i_io_wr, i_io_addr,
                           T8CF_OFF_CMP_A);
        wr_cmp_b = reg_sel(i_ds_wr, i_ds_addr, i_io_wr, i_io_addr,
                           T8CF_OFF_CMP_B);
        wr_mask  = reg_sel(i_ds_wr, i_ds_addr, i_io_wr, i_io_addr,
                           T8CF_OFF_MASK);
        rd_any   = i_ds_rd || i_io_rd;
    end

    // Both compare channels are the same logic, so they are generated.
    assign chan_compare[0] = compare_a_value_reg;
    assign chan_compare[1] = compare_b_value_reg;
    assign chan_force      = {i_force_compare_b_strobe,
                              i_force_compare_a_strobe};

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            t8cf_match u_match (
                .i_clk     (i_clk),
                .i_sys_rst (i_sys_rst),
                .i_tick    (i_timer_tick),
                .i_count   (i_timer8_count_value),
                .i_compare (chan_compare[ch]),
                .i_block   (block_reg),
                .i_force   (chan_force[ch]),
                .o_match   (chan_match[ch]),
                .o_wave    (chan_wave[ch])
            );
        end
    endgenerate

    // Flag events: hardware sets, vectors and written ones clear.
    always_comb begin
        ovf_hit = i_timer_tick &&
                  ovf_point(i_waveform_mode_bits, i_timer8_count_value,
                            compare_a_value_reg);
        flag_set = '0;
        flag_set[T8CF_BIT_OVF]   = ovf_hit;
        flag_set[T8CF_BIT_CMP_A] = chan_match[0];
        flag_set[T8CF_BIT_CMP_B] = chan_match[1];
        vector_ack = '0;
        vector_ack[T8CF_BIT_OVF]   = i_vector_ack_overflow;
        vector_ack[T8CF_BIT_CMP_A] = i_vector_ack_compare_a;
        vector_ack[T8CF_BIT_CMP_B] = i_vector_ack_compare_b;
        flag_clr = vector_ack |
                   ({T8CF_NFLAGS{wr_flags}} &
                    i_wdata[T8CF_NFLAGS-1:0]);
    end

    // Next state of all registers. A set in the same cycle as a clear
    // wins so that no event is lost while software services the flag.
    always_comb begin
        compare_a_value_next      = compare_a_value_reg;
        compare_b_value_next      = compare_b_value_reg;
        irq_enable_next           = irq_enable_reg;
        timer8_flag_register_next = (timer8_flag_register_reg & ~flag_clr)
                                    | flag_set;
        block_next                = block_reg;
        load_next                 = wr_count;
        load_data_next            = load_data_reg;
        rd_ack_next               = rd_any;
        rdata_next                = rdata_reg;
        if (wr_cmp_a) begin
            compare_a_value_next = i_wdata;
        end
        if (wr_cmp_b) begin
            compare_b_value_next = i_wdata;
        end
        if (wr_mask) begin
            irq_enable_next = i_wdata[T8CF_NFLAGS-1:0];
        end
        // The block covers exactly the tick after the counter write.
        if (wr_count) begin
            block_next     = 1'b1;
            load_data_next = i_wdata;
        end else if (i_timer_tick) begin
            block_next = 1'b0;
        end
        if (rd_any) begin
            rdata_next = T8CF_RST_BYTE;
            if (reg_sel(i_ds_rd, i_ds_addr, i_io_rd, i_io_addr,
                        T8CF_OFF_FLAGS)) begin
                rdata_next = {5'h00, timer8_flag_register_reg};
            end else if (reg_sel(i_ds_rd, i_ds_addr, i_io_rd, i_io_addr,
                                 T8CF_OFF_COUNT)) begin
                rdata_next = i_timer8_count_value;
            end else if (reg_sel(i_ds_rd, i_ds_addr, i_io_rd, i_io_addr,
                                 T8CF_OFF_CMP_A)) begin
                rdata_next = compare_a_value_reg;
            end else if (reg_sel(i_ds_rd, i_ds_addr, i_io_rd, i_io_addr,
                                 T8CF_OFF_CMP_B)) begin
                rdata_next = compare_b_value_reg;
            end else if (reg_sel(i_ds_rd, i_ds_addr, i_io_rd, i_io_addr,
                                 T8CF_OFF_MASK)) begin
                rdata_next = {5'h00, irq_enable_reg};
            end
        end
    end

    // Register bank.
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            compare_a_value_reg      <= T8CF_RST_BYTE;
            compare_b_value_reg      <= T8CF_RST_BYTE;
            irq_enable_reg           <= T8CF_RST_FLAGS;
            timer8_flag_register_reg <= T8CF_RST_FLAGS;
            block_reg                <= 1'b0;
            load_reg                 <= 1'b0;
            load_data_reg            <= T8CF_RST_BYTE;
            rd_ack_reg               <= 1'b0;
            rdata_reg                <= T8CF_RST_BYTE;
        end else begin
            compare_a_value_reg      <= compare_a_value_next;
            compare_b_value_reg      <= compare_b_value_next;
            irq_enable_reg           <= irq_enable_next;
            timer8_flag_register_reg <= timer8_flag_register_next;
            block_reg                <= block_next;
            load_reg                 <= load_next;
            load_data_reg            <= load_data_next;
            rd_ack_reg               <= rd_ack_next;
            rdata_reg                <= rdata_next;
        end
    end

    // Outputs; interrupt requests are gated levels for the CPU.
    assign o_rdata            = rdata_reg;
    assign o_rd_ack           = rd_ack_reg;
    assign o_count_load       = load_reg;
    assign o_count_load_data  = load_data_reg;
    assign o_waveform_out_a   = chan_wave[0];
    assign o_waveform_out_b   = chan_wave[1];
    // Only true matches clear the counter, so a forced strobe cannot.
    assign o_clear_on_match_a = chan_match[0];
    assign o_clear_on_match_b = chan_match[1];
    assign o_irq_overflow  = i_global_irq_enable &&
                             irq_enable_reg[T8CF_BIT_OVF] &&
                             timer8_flag_register_reg[T8CF_BIT_OVF];
    assign o_irq_compare_a = i_global_irq_enable &&
                             irq_enable_reg[T8CF_BIT_CMP_A] &&
                             timer8_flag_register_reg[T8CF_BIT_CMP_A];
    assign o_irq_compare_b = i_global_irq_enable &&
                             irq_enable_reg[T8CF_BIT_CMP_B] &&
                             timer8_flag_register_reg[T8CF_BIT_CMP_B];

    property p_cmp_a_flag;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_timer_tick && !block_reg &&
         i_timer8_count_value == compare_a_value_reg)
        |=> ##1 timer8_flag_register_reg[T8CF_BIT_CMP_A];
    endproperty
    a_cmp_a_flag: assert property (p_cmp_a_flag)
        else $error("Compare A match did not set its flag.");

    property p_cmp_b_flag;
        @(posedge i_clk) disable iff (i_sys_rst)
        chan_match[1] |=> timer8_flag_register_reg[T8CF_BIT_CMP_B];
    endproperty
    a_cmp_b_flag: assert property (p_cmp_b_flag)
        else $error("Compare B match did not set its flag.");

    // The block flag stands from the counter write up to the next tick, so
    // checking that tick covers any gap between the write and the tick.
    property p_block;
        @(posedge i_clk) disable iff (i_sys_rst)
        (block_reg && i_timer_tick) |=> !chan_match[0] && !chan_match[1];
    endproperty
    a_block: assert property (p_block)
        else $error("Match seen on the tick after a counter write.");

    property p_w1c_a;
        @(posedge i_clk) disable iff (i_sys_rst)
        (wr_flags && i_wdata[T8CF_BIT_CMP_A] && !chan_match[0])
        |=> !timer8_flag_register_reg[T8CF_BIT_CMP_A];
    endproperty
    a_w1c_a: assert property (p_w1c_a)
        else $error("Written one failed to clear compare A flag.");

    property p_vec_b;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_vector_ack_compare_b && !chan_match[1])
        |=> !timer8_flag_register_reg[T8CF_BIT_CMP_B];
    endproperty
    a_vec_b: assert property (p_vec_b)
        else $error("Vector failed to clear compare B flag.");

    property p_zero_keeps;
        @(posedge i_clk) disable iff (i_sys_rst)
        (wr_flags && !i_wdata[T8CF_BIT_OVF] && !i_vector_ack_overflow)
        |=> timer8_flag_register_reg[T8CF_BIT_OVF] ==
            ($past(timer8_flag_register_reg[T8CF_BIT_OVF]) ||
             $past(ovf_hit));
    endproperty
    a_zero_keeps: assert property (p_zero_keeps)
        else $error("Writing zero changed the overflow flag.");

    property p_ext_io;
        @(posedge i_clk) disable iff (i_sys_rst)
        !(i_ds_wr && i_ds_addr == T8CF_OFF_MASK) |=> $stable(irq_enable_reg);
    endproperty
    a_ext_io: assert property (p_ext_io)
        else $error("Mask register changed without a data-space write.");

    property p_ovf_floor;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_timer_tick && i_waveform_mode_bits == T8CF_MODE_PC_MAX &&
         i_timer8_count_value == T8CF_COUNT_FLOOR)
        |=> timer8_flag_register_reg[T8CF_BIT_OVF];
    endproperty
    a_ovf_floor: assert property (p_ovf_floor)
        else $error("Overflow flag missed at the counter floor.");

    property p_irq_b;
        @(posedge i_clk) disable iff (i_sys_rst)
        (chan_match[1] && irq_enable_reg[T8CF_BIT_CMP_B] && !wr_mask)
        |=> (o_irq_compare_b == i_global_irq_enable);
    endproperty
    a_irq_b: assert property (p_irq_b)
        else $error("Compare B interrupt without its three conditions.");

    property p_rd_upper;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_ds_rd && i_ds_addr == T8CF_OFF_FLAGS) |=> o_rd_ack &&
        o_rdata[7:T8CF_NFLAGS] == 5'h00;
    endproperty
    a_rd_upper: assert property (p_rd_upper)
        else $error("Upper flag bits did not read as zero.");
endmodule // t8cf_top

// ==== testbench/timer8_compare_and_flags_tb_top.sv ====
// Self-checking bench for the timer compare registers and interrupt flags.
`timescale 1ns/1ps
module timer8_compare_and_flags_tb_top;
    import t8cf_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic [5:0]  i_io_addr = 6'h00;
    logic        i_io_wr = 1'b0;
    logic        i_io_rd = 1'b0;
    logic [15:0] i_ds_addr = 16'h0000;
    logic        i_ds_wr = 1'b0;
    logic        i_ds_rd = 1'b0;
    logic [7:0]  i_wdata = 8'h00;
    logic        i_tick = 1'b0;
    logic [7:0]  i_cnt = 8'h00;
    t8cf_mode_t  i_mode = T8CF_MODE_NORMAL;
    logic [1:0]  i_force = 2'h0;
    logic        i_gie = 1'b0;
    logic [2:0]  i_vec = 3'h0;
    logic [7:0]  o_rdata;
    logic        o_rd_ack;
    logic        o_load;
    logic [7:0]  o_load_data;
    logic [1:0]  o_wave;
    logic [1:0]  o_clr;
    logic [2:0]  o_irq;
    int          errors = 0;
    int          checked = 0;
    logic [7:0]  v;
    t8cf_mode_t  modes [6] = '{T8CF_MODE_NORMAL, T8CF_MODE_PC_MAX,
                              T8CF_MODE_FAST_MAX, T8CF_MODE_PC_TOP,
                              T8CF_MODE_CTC, T8CF_MODE_FAST_TOP};
    logic [7:0]  ends [6] = '{8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h30};
    // Compare-top mode ends on the compare A value, so that flag joins in.
    logic [7:0]  exps [6] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h03};

    t8cf_top uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_io_addr(i_io_addr),
        .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_ds_addr(i_ds_addr),
        .i_ds_wr(i_ds_wr), .i_ds_rd(i_ds_rd), .i_wdata(i_wdata),
        .o_rdata(o_rdata), .o_rd_ack(o_rd_ack), .i_timer_tick(i_tick),
        .i_timer8_count_value(i_cnt), .i_waveform_mode_bits(i_mode),
        .i_force_compare_a_strobe(i_force[0]),
        .i_force_compare_b_strobe(i_force[1]), .i_global_irq_enable(i_gie),
        .i_vector_ack_overflow(i_vec[0]), .i_vector_ack_compare_a(i_vec[1]),
        .i_vector_ack_compare_b(i_vec[2]), .o_count_load(o_load),
        .o_count_load_data(o_load_data), .o_waveform_out_a(o_wave[0]),
        .o_waveform_out_b(o_wave[1]), .o_clear_on_match_a(o_clr[0]),
        .o_clear_on_match_b(o_clr[1]), .o_irq_overflow(o_irq[0]),
        .o_irq_compare_a(o_irq[1]), .o_irq_compare_b(o_irq[2]));

    // Free-running 25 MHz clock.
    always #20 i_clk = ~i_clk;

    // Verdict and end of run; also reached from the watchdog.
    task automatic close_out();
        if (errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Byte comparison with case equality so unknowns never match.
    task automatic chk8(input string n, input logic [7:0] e,
                        input logic [7:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    // Every driver starts just after a rising edge and ends at the same spot.
    task automatic step();
        @(posedge i_clk);
        #1;
    endtask

    // Register write through the short I/O window or the data space; the
    // lead-in edge keeps the strobes of two calls in a row apart.
    task automatic wr(input bit io, input logic [15:0] a, input logic [7:0] d);
        logic [15:0] ia;
        ia = a - T8CF_IO_SHIFT;
        step();
        i_io_addr = ia[5:0];
        i_ds_addr = a;
        i_wdata = d;
        i_io_wr = io;
        i_ds_wr = !io;
        step();
        i_io_wr = 1'b0;
        i_ds_wr = 1'b0;
    endtask

    // Register read after a lead-in edge; the acknowledge stands for one cycle, the data until the next read.
    task automatic rdc(input bit io, input logic [15:0] a,
                       input logic [7:0] e);
        logic [15:0] ia;
        ia = a - T8CF_IO_SHIFT;
        step();
        i_io_addr = ia[5:0];
        i_ds_addr = a;
        i_io_rd = io;
        i_ds_rd = !io;
        step();
        i_io_rd = 1'b0;
        i_ds_rd = 1'b0;
        chk8("rd_ack", 8'h01, {7'h0, o_rd_ack});
        chk8("rdata", e, o_rdata);
    endtask

    // One timer tick carrying the given counter value.
    task automatic tick(input logic [7:0] c);
        i_cnt = c;
        i_tick = 1'b1;
        step();
        i_tick = 1'b0;
    endtask

    // One-cycle vector acknowledge for flag bit b.
    task automatic vec(input int b);
        i_vec = 3'h1 << b;
        step();
        i_vec = 3'h0;
    endtask

    // Hang guard: the sequence needs about 155 cycles.
    initial begin
        #(40 * 3000);
        errors++;
        close_out();
    end

    initial begin
        repeat (10) @(posedge i_clk);
        #1;
        i_sys_rst = 1'b0;
        step();
        rdc(1, T8CF_OFF_FLAGS, 8'h00);
        rdc(0, T8CF_OFF_CMP_A, 8'h00);
        rdc(1, T8CF_OFF_CMP_B, 8'h00);
        rdc(0, T8CF_OFF_MASK, 8'h00);
        wr(1, T8CF_OFF_CMP_A, 8'h5A);
        rdc(0, T8CF_OFF_CMP_A, 8'h5A);
        wr(0, T8CF_OFF_CMP_B, 8'hA5);
        rdc(1, T8CF_OFF_CMP_B, 8'hA5);
        wr(0, T8CF_OFF_MASK, 8'h07);
        // A short I/O write aimed at the mask must land nowhere.
        wr(1, T8CF_OFF_MASK, 8'h00);
        rdc(0, T8CF_OFF_MASK, 8'h07);
        rdc(0, 16'h0070, 8'h00);
        i_gie = 1'b1;
        // Both compare channels: match, gating, both ways of clearing.
        for (int c = 0; c < 2; c++) begin
            v = 8'h02 << c;
            wr(c == 0, c ? T8CF_OFF_CMP_B : T8CF_OFF_CMP_A,
               8'h30 + c);
            tick(8'h30 + c);
            chk8("clr", 8'h01, {7'h0, o_clr[c]});
            chk8("wave", 8'h01, {7'h0, o_wave[c]});
            step();
            rdc(1, T8CF_OFF_FLAGS, v);
            chk8("irq", 8'h01, {7'h0, o_irq[c+1]});
            i_gie = 1'b0;
            step();
            chk8("irq", 8'h00, {7'h0, o_irq[c+1]});
            i_gie = 1'b1;
            wr(0, T8CF_OFF_MASK, 8'h07 & ~v);
            chk8("irq", 8'h00, {7'h0, o_irq[c+1]});
            wr(0, T8CF_OFF_MASK, 8'h07);
            chk8("irq", 8'h01, {7'h0, o_irq[c+1]});
            wr(1, T8CF_OFF_FLAGS, 8'h00);
            rdc(0, T8CF_OFF_FLAGS, v);
            vec(c + 1);
            rdc(1, T8CF_OFF_FLAGS, 8'h00);
            tick(8'h30 + c);
            step();
            wr(c == 0, T8CF_OFF_FLAGS, v);
            rdc(1, T8CF_OFF_FLAGS, 8'h00);
        end
        // Overflow point follows the mode bits.
        tick(8'h00);
        step();
        rdc(1, T8CF_OFF_FLAGS, 8'h00);
        for (int m = 0; m < 6; m++) begin
            i_mode = modes[m];
            tick(ends[m]);
            step();
            rdc(1, T8CF_OFF_FLAGS, exps[m]);
            chk8("irq_ovf", 8'h01, {7'h0, o_irq[0]});
            if (m == 0) vec(0);
            else wr(0, T8CF_OFF_FLAGS, exps[m]);
            rdc(1, T8CF_OFF_FLAGS, 8'h00);
        end
        i_mode = T8CF_MODE_NORMAL;
        // A counter write removes the match on the following tick only.
        wr(1, T8CF_OFF_COUNT, 8'h30);
        chk8("load", 8'h01, {7'h0, o_load});
        chk8("load_data", 8'h30, o_load_data);
        tick(8'h30);
        chk8("clr", 8'h00, {7'h0, o_clr[0]});
        step();
        rdc(1, T8CF_OFF_FLAGS, 8'h00);
        tick(8'h30);
        step();
        rdc(1, T8CF_OFF_FLAGS, 8'h02);
        wr(1, T8CF_OFF_FLAGS, 8'h02);
        // Forced compares move the waveform and nothing else.
        for (int c = 0; c < 2; c++) begin
            i_force = 2'h1 << c;
            step();
            i_force = 2'h0;
            chk8("wave", 8'h01, {7'h0, o_wave[c]});
            chk8("clr", 8'h00, {7'h0, o_clr[c]});
            step();
            rdc(1, T8CF_OFF_FLAGS, 8'h00);
        end
        close_out();
    end
endmodule // timer8_compare_and_flags_tb_top
